// *** csr_pkg.sv ***
/*
 * Shared constants and types for the core special register block.
 * Assumes a single core clock and a processor sequencer that issues one request per cycle.
 */
`default_nettype none

package csr_pkg;

    // ****************************************
    // Widths and data memory map
    // ****************************************
    localparam int DATA_W   = 8;
    localparam int ADDR_W   = 8;
    localparam int PC_W     = 11;
    localparam int GP_DEPTH = 96;

    localparam logic [7:0] ADR_IND0    = 8'h00;
    localparam logic [7:0] ADR_PTR0    = 8'h01;
    localparam logic [7:0] ADR_IND1    = 8'h02;
    localparam logic [7:0] ADR_PTR1    = 8'h03;
    localparam logic [7:0] ADR_ACC     = 8'h05;
    localparam logic [7:0] ADR_PC_LO   = 8'h06;
    localparam logic [7:0] ADR_FLAGS   = 8'h0a;
    localparam logic [7:0] ADR_PT_DATA = 8'h12;
    localparam logic [7:0] ADR_PT_DIR  = 8'h13;
    localparam logic [7:0] ADR_GP_BASE = 8'h40;

    // ****************************************
    // Flag bit positions and reset values
    // ****************************************
    localparam int FLG_WDT = 5;
    localparam int FLG_SLP = 4;
    localparam int FLG_SR  = 3;
    localparam int FLG_Z   = 2;
    localparam int FLG_HN  = 1;
    localparam int FLG_C   = 0;

    localparam logic [7:0] READ_ZERO   = 8'h00;
    localparam logic [7:0] RST_BYTE    = 8'h00;
    localparam logic [7:0] RST_PT_DIR  = 8'hff;
    localparam logic [7:0] RST_PT_DATA = 8'h00;
    localparam logic [3:0] RST_ALU_FLG = 4'h0;

    // ****************************************
    // Request and ALU types
    // ****************************************
    typedef enum logic [3:0] {
        OP_NOP  = 4'h0,
        OP_LDI  = 4'h1,
        OP_LDM  = 4'h2,
        OP_STM  = 4'h3,
        OP_ADD  = 4'h4,
        OP_ADC  = 4'h5,
        OP_SUB  = 4'h6,
        OP_SBC  = 4'h7,
        OP_AND  = 4'h8,
        OP_OR   = 4'h9,
        OP_XOR  = 4'ha,
        OP_RLC  = 4'hb,
        OP_RRC  = 4'hc,
        OP_BSET = 4'hd,
        OP_BCLR = 4'he,
        OP_CLRM = 4'hf
    } csr_op_e;

    typedef struct packed {
        csr_op_e    op;
        logic [7:0] addr;
        logic [7:0] imm;
        logic [2:0] bit_sel;
    } csr_req_s;

    typedef struct packed {
        logic sr;
        logic z;
        logic hn;
        logic c;
    } csr_alu_flags_s;

    typedef struct packed {
        logic [7:0]     res;
        csr_alu_flags_s flg;
    } csr_alu_s;

endpackage

`default_nettype wire

// *** csr_core_special_registers.sv ***
/*
 * Special function register logic of an 8-bit core: indirect ports and pointers, accumulator
 * and ALU flags, program counter low byte, status flags and port A data/direction.
 * Assumes the sequencer holds req stable while req_valid is high and req_ready is low, and
 * that watchdog and sleep events come from logic on core_clk.
 */
`default_nettype none

// Operation
// - Unused locations between special registers and general memory read as 00H.
// - Indirect port access goes to the address in its pointer, never itself.
// - Indirect port 0 uses pointer 0; indirect port 1 uses pointer 1.
// - Pointer aimed at an indirect port: read gives 00H, write does nothing.
// - Pointers are real registers, read and written like any other.
// - ALU results go to accumulator; no direct register-to-register move.
// - Writing program counter low byte jumps within the current page.
// - A program counter low byte write inserts one dummy cycle.
// - Status writes leave watchdog expired and sleep entered flags unchanged.
// - Watchdog expired: set by time-out, cleared by reset, watchdog clear, sleep.
// - Sleep entered: set by sleep, cleared by reset or watchdog clear.
// - Signed range flag set when carry into MSB differs from carry out.
// - Result null flag set when result is zero, cleared otherwise.
// - Half nibble flag: low nibble carry on add, no high-nibble borrow on subtract.
// - Arithmetic out bit: carry on add, no borrow on subtract, else cleared.
// - Rotate through carry shifts via arithmetic out bit.
// - Interrupts and calls never stack the status register.
// - Status bits 7:6 read zero; bits 3:0 are read/write.
// - Direction bit one makes the pin input, zero makes it output.
// - Port registers accept single-bit set/clear, direction changeable any time.

module csr_core_special_registers #(
    parameter int PC_W = csr_pkg::PC_W
) (
    input  wire logic              core_clk,
    input  wire logic              reset_n,
    input  wire logic              req_valid,
    input  wire csr_pkg::csr_req_s req,
    output logic                   req_ready,
    input  wire logic              wdt_timeout,
    input  wire logic              watchdog_clear_op_op,
    input  wire logic              sleep_op,
    input  wire logic [7:0]        pad_a_in,
    output logic [7:0]             pad_a_out,
    output logic [7:0]             pad_a_oe,
    output logic [7:0]             rd_data_q,
    output logic [7:0]             acc_q,
    output logic [7:0]             flags_rd,
    output logic [PC_W-1:0]        pc_q,
    output logic                   dummy_q
);

    // ****************************************
    // Helper functions
    // ****************************************

    // Eight-bit adder with all four arithmetic flags
    function automatic csr_pkg::csr_alu_s alu_add(input logic [7:0] a, input logic [7:0] b, input logic cin);
        logic [4:0]        lo;
        logic [7:0]        low7;
        logic [8:0]        full;
        csr_pkg::csr_alu_s r;
        lo       = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        low7     = {1'b0, a[6:0]} + {1'b0, b[6:0]} + {7'h00, cin};
        full     = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        r.res    = full[7:0];
        r.flg.c  = full[8];
        r.flg.hn = lo[4];
        r.flg.sr = low7[7] ^ full[8];
        r.flg.z  = (full[7:0] == 8'h00);
        return r;
    endfunction

    // True for the two indirect port locations
    function automatic logic is_ind(input logic [7:0] a);
        return (a == csr_pkg::ADR_IND0) || (a == csr_pkg::ADR_IND1);
    endfunction

    // ****************************************
    // Reset release and pin synchroniser
    // ****************************************
    logic       rst_meta_q;
    logic       rst_n_q;
    logic [7:0] pad_meta_q;
    logic [7:0] pad_sync_q;

    // Reset asserts at once, releases after two edges
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // Pins are asynchronous to the core clock
    always_ff @(posedge core_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            pad_meta_q <= csr_pkg::RST_BYTE;
            pad_sync_q <= csr_pkg::RST_BYTE;
        end
        else
        begin
            pad_meta_q <= pad_a_in;
            pad_sync_q <= pad_meta_q;
        end
    end
    // ****************************************
    // Storage
    // ****************************************
    logic [7:0] ptr0_q;
    logic [7:0] ptr1_q;
    logic [3:0] alu_flg_q;
    logic       wdt_flag_q;
    logic       sleep_flag_q;
    logic [7:0] pt_data_q;
    logic [7:0] pt_dir_q;
    logic [7:0] gp_mem [csr_pkg::GP_DEPTH];

    // ****************************************
    // Address resolution and read mux
    // ****************************************
    logic       fire;
    logic [7:0] eff_addr;
    logic       blocked;
    logic [7:0] opnd;
    logic [7:0] gp_idx;
    logic       gp_hit;

    assign req_ready = !dummy_q;
    assign fire      = req_valid && req_ready;

    // Indirect ports never address themselves
    always_comb
    begin
        eff_addr = req.addr;
        if (req.addr == csr_pkg::ADR_IND0)
            eff_addr = ptr0_q;
        else if (req.addr == csr_pkg::ADR_IND1)
            eff_addr = ptr1_q;
        blocked = is_ind(eff_addr);
    end

    assign gp_idx = 8'(eff_addr - csr_pkg::ADR_GP_BASE);
    assign gp_hit = (eff_addr >= csr_pkg::ADR_GP_BASE) && (gp_idx < 8'(csr_pkg::GP_DEPTH));

    // Operand fetch; holes and blocked accesses give zero
    always_comb
    begin
        opnd = csr_pkg::READ_ZERO;
        if (!blocked)
        begin
            if (gp_hit)
                opnd = gp_mem[gp_idx[6:0]];
            else
            begin
                unique case (eff_addr)
                    csr_pkg::ADR_PTR0:    opnd = ptr0_q;
                    csr_pkg::ADR_PTR1:    opnd = ptr1_q;
                    csr_pkg::ADR_ACC:     opnd = acc_q;
                    csr_pkg::ADR_PC_LO:   opnd = pc_q[7:0];
                    csr_pkg::ADR_FLAGS:   opnd = flags_rd;
                    csr_pkg::ADR_PT_DATA: opnd = (pt_dir_q & pad_sync_q) | (~pt_dir_q & pt_data_q);
                    csr_pkg::ADR_PT_DIR:  opnd = pt_dir_q;
                    default:              opnd = csr_pkg::READ_ZERO;
                endcase
            end
        end
    end

    // ****************************************
    // Execute: accumulator result or memory write
    // ****************************************
    logic                        acc_ld;
    logic [7:0]                  acc_d;
    logic                        mem_wr;
    logic [7:0]                  wval;
    logic [3:0]                  flg_mask;
    csr_pkg::csr_alu_flags_s     flg_new;
    csr_pkg::csr_alu_s           sum;
    logic [7:0]                  logic_res;

    // Only the accumulator receives ALU results; memory writes carry acc, a bit edit or zero
    always_comb
    begin
        acc_ld    = 1'b0;
        acc_d     = acc_q;
        mem_wr    = 1'b0;
        wval      = acc_q;
        flg_mask  = 4'h0;
        flg_new   = csr_pkg::RST_ALU_FLG;
        logic_res = 8'h00;
        sum       = alu_add(acc_q, opnd, 1'b0);
        unique case (req.op)
            csr_pkg::OP_NOP: ;
            csr_pkg::OP_LDI:
            begin
                acc_ld = 1'b1;
                acc_d  = req.imm;
            end
            csr_pkg::OP_LDM:
            begin
                acc_ld = 1'b1;
                acc_d  = opnd;
            end
            csr_pkg::OP_STM:
                mem_wr = 1'b1;
            csr_pkg::OP_ADD, csr_pkg::OP_ADC, csr_pkg::OP_SUB, csr_pkg::OP_SBC:
            begin
                if (req.op == csr_pkg::OP_ADC)
                    sum = alu_add(acc_q, opnd, alu_flg_q[csr_pkg::FLG_C]);
                else if (req.op == csr_pkg::OP_SUB)
                    sum = alu_add(acc_q, ~opnd, 1'b1);          // Carry out means no borrow
                else if (req.op == csr_pkg::OP_SBC)
                    sum = alu_add(acc_q, ~opnd, alu_flg_q[csr_pkg::FLG_C]);
                acc_ld   = 1'b1;
                acc_d    = sum.res;
                flg_mask = 4'hf;
                flg_new  = sum.flg;
            end
            csr_pkg::OP_AND, csr_pkg::OP_OR, csr_pkg::OP_XOR:
            begin
                if (req.op == csr_pkg::OP_AND)
                    logic_res = acc_q & opnd;
                else if (req.op == csr_pkg::OP_OR)
                    logic_res = acc_q | opnd;
                else
                    logic_res = acc_q ^ opnd;
                acc_ld                   = 1'b1;
                acc_d                    = logic_res;
                flg_mask[csr_pkg::FLG_Z] = 1'b1;
                flg_new.z                = (logic_res == 8'h00);
            end
            csr_pkg::OP_RLC:
            begin
                acc_ld                   = 1'b1;
                acc_d                    = {opnd[6:0], alu_flg_q[csr_pkg::FLG_C]};
                flg_mask[csr_pkg::FLG_C] = 1'b1;
                flg_new.c                = opnd[7];
            end
            csr_pkg::OP_RRC:
            begin
                acc_ld                   = 1'b1;
                acc_d                    = {alu_flg_q[csr_pkg::FLG_C], opnd[7:1]};
                flg_mask[csr_pkg::FLG_C] = 1'b1;
                flg_new.c                = opnd[0];
            end
            csr_pkg::OP_BSET:
            begin
                mem_wr = 1'b1;
                wval   = opnd | (8'h01 << req.bit_sel);
            end
            csr_pkg::OP_BCLR:
            begin
                mem_wr = 1'b1;
                wval   = opnd & ~(8'h01 << req.bit_sel);
            end
            csr_pkg::OP_CLRM:
            begin
                mem_wr = 1'b1;
                wval   = 8'h00;
            end
        endcase
    end
    logic do_wr;
    assign do_wr = fire && mem_wr && !blocked;

    // ****************************************
    // Register updates
    // ****************************************

    // Pointers behave as plain registers
    always_ff @(posedge core_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            ptr0_q <= csr_pkg::RST_BYTE;
            ptr1_q <= csr_pkg::RST_BYTE;
        end
        else if (do_wr)
        begin
            if (eff_addr == csr_pkg::ADR_PTR0)
                ptr0_q <= wval;
            if (eff_addr == csr_pkg::ADR_PTR1)
                ptr1_q <= wval;
        end
    end

    // Accumulator and operand readback
    always_ff @(posedge core_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            acc_q     <= csr_pkg::RST_BYTE;
            rd_data_q <= csr_pkg::RST_BYTE;
        end
        else if (fire)
        begin
            rd_data_q <= opnd;
            if (acc_ld)
                acc_q <= acc_d;
            else if (do_wr && eff_addr == csr_pkg::ADR_ACC)
                acc_q <= wval;
        end
    end

    // Arithmetic flags; a direct write takes the low four bits only
    always_ff @(posedge core_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
            alu_flg_q <= csr_pkg::RST_ALU_FLG;                  // Defined here though software must not rely on it
        else if (do_wr && eff_addr == csr_pkg::ADR_FLAGS)
            alu_flg_q <= wval[3:0];
        else if (fire)
            alu_flg_q <= (alu_flg_q & ~flg_mask) | (flg_new & flg_mask);
    end

    // System flags ignore data writes; a set beats a clear in the same cycle
    always_ff @(posedge core_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            wdt_flag_q   <= 1'b0;
            sleep_flag_q <= 1'b0;
        end
        else
        begin
            if (wdt_timeout)
                wdt_flag_q <= 1'b1;
            else if (watchdog_clear_op_op || sleep_op)
                wdt_flag_q <= 1'b0;
            if (sleep_op)
                sleep_flag_q <= 1'b1;
            else if (watchdog_clear_op_op)
                sleep_flag_q <= 1'b0;
        end
    end

    // Upper two bits are not implemented
    assign flags_rd = {2'b00, wdt_flag_q, sleep_flag_q, alu_flg_q};

    // Program counter; low byte write jumps in page and costs a dummy cycle.
    // The status byte has no path to the return stack, only pc_q is pushed by the sequencer.
    always_ff @(posedge core_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            pc_q    <= '0;
            dummy_q <= 1'b0;
        end
        else
        begin
            dummy_q <= 1'b0;
            if (fire)
            begin
                if (do_wr && eff_addr == csr_pkg::ADR_PC_LO)
                begin
                    pc_q    <= {pc_q[PC_W-1:8], wval};
                    dummy_q <= 1'b1;
                end
                else
                    pc_q <= PC_W'(pc_q + 1'b1);
            end
        end
    end

    // Port A latches; direction may change at any time
    always_ff @(posedge core_clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            pt_data_q <= csr_pkg::RST_PT_DATA;
            pt_dir_q  <= csr_pkg::RST_PT_DIR;
        end
        else if (do_wr)
        begin
            if (eff_addr == csr_pkg::ADR_PT_DATA)
                pt_data_q <= wval;
            if (eff_addr == csr_pkg::ADR_PT_DIR)
                pt_dir_q <= wval;
        end
    end

    assign pad_a_out = pt_data_q;
    assign pad_a_oe  = ~pt_dir_q;

    // General purpose RAM holds no reset, as in any data memory
    always_ff @(posedge core_clk)
    begin
        if (do_wr && gp_hit)
            gp_mem[gp_idx[6:0]] <= wval;
    end

endmodule // csr_core_special_registers

`default_nettype wire

// *** csr_checker.sv ***
/*
 * Port-level assertion checker for the core special register block.
 * Assumes it is bound to csr_core_special_registers and sees only that module's ports.
 */
`default_nettype none

module csr_checker #(
    parameter int PC_W = csr_pkg::PC_W
) (
    input wire logic              core_clk,
    input wire logic              reset_n,
    input wire logic              req_valid,
    input wire csr_pkg::csr_req_s req,
    input wire logic              req_ready,
    input wire logic              wdt_timeout,
    input wire logic              watchdog_clear_op_op,
    input wire logic              sleep_op,
    input wire logic [7:0]        pad_a_in,
    input wire logic [7:0]        pad_a_out,
    input wire logic [7:0]        pad_a_oe,
    input wire logic [7:0]        rd_data_q,
    input wire logic [7:0]        acc_q,
    input wire logic [7:0]        flags_rd,
    input wire logic [PC_W-1:0]   pc_q,
    input wire logic              dummy_q
);
    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    // Accepted request and the store to the program counter low byte
    logic take;
    logic jmp_wr;
    assign take   = req_valid && req_ready;
    assign jmp_wr = take && req.op == csr_pkg::OP_STM && req.addr == csr_pkg::ADR_PC_LO;

    a_top_bits_zero: assert property (flags_rd[7:6] == 2'b00)
        else $error("status top bits not zero");
    a_jmp_dummy: assert property (jmp_wr |=> dummy_q && !req_ready ##1 !dummy_q)
        else $error("jump did not insert exactly one dummy cycle");
    a_jmp_page: assert property (jmp_wr |=> pc_q[7:0] == $past(acc_q)
        && pc_q[PC_W-1:8] == $past(pc_q[PC_W-1:8])) else $error("jump target or page wrong");
    a_wdt_set: assert property (wdt_timeout |=> flags_rd[5])
        else $error("time-out did not set expired flag");
    a_sleep_set: assert property (sleep_op |=> flags_rd[4] && flags_rd[5] == $past(wdt_timeout))
        else $error("sleep flag update wrong");
    a_wdt_stable: assert property (!wdt_timeout && !watchdog_clear_op_op && !sleep_op |=> $stable(flags_rd[5]))
        else $error("expired flag changed without cause");
    a_slp_stable: assert property (!sleep_op && !watchdog_clear_op_op |=> $stable(flags_rd[4]))
        else $error("sleep flag changed without cause");
    a_clr_both: assert property (watchdog_clear_op_op && !wdt_timeout && !sleep_op |=> flags_rd[5:4] == 2'b00)
        else $error("watchdog clear left a flag set");
    a_dir_oe: assert property (take && req.op == csr_pkg::OP_STM && req.addr == csr_pkg::ADR_PT_DIR
        |=> pad_a_oe == ~$past(acc_q)) else $error("output enable not inverse of direction");
    a_data_out: assert property (take && req.op == csr_pkg::OP_STM && req.addr == csr_pkg::ADR_PT_DATA
        |=> pad_a_out == $past(acc_q)) else $error("port data latch not driven out");
    a_ldi_acc: assert property (take && req.op == csr_pkg::OP_LDI |=> acc_q == $past(req.imm))
        else $error("load immediate missed accumulator");
    a_add_zero: assert property (take && req.op == csr_pkg::OP_ADD |=> flags_rd[2] == (acc_q == 8'h00))
        else $error("zero flag disagrees with sum");

    // Main scenarios reached
    c_jump: cover property (jmp_wr);
    c_sleep: cover property (sleep_op);
    c_timeout: cover property (wdt_timeout);
endmodule // csr_checker

bind csr_core_special_registers csr_checker #(.PC_W(PC_W)) u_chk (
    .core_clk(core_clk), .reset_n(reset_n), .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .wdt_timeout(wdt_timeout), .watchdog_clear_op_op(watchdog_clear_op_op), .sleep_op(sleep_op), .pad_a_in(pad_a_in),
    .pad_a_out(pad_a_out), .pad_a_oe(pad_a_oe), .rd_data_q(rd_data_q), .acc_q(acc_q),
    .flags_rd(flags_rd), .pc_q(pc_q), .dummy_q(dummy_q));

`default_nettype wire

// *** tb.sv ***
/*
 * Self-checking bench for the core special register block.
 * Assumes csr_pkg, the design and the checker are compiled before it.
 */
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************
    // Signals, tasks and scoreboard
    // ****************************************
    typedef struct { string n; logic [7:0] e; logic [7:0] m; } csr_note_s;
    logic                     core_clk, reset_n, req_valid, req_ready, dummy_q;
    logic                     wdt_timeout, watchdog_clear_op_op, sleep_op;
    csr_pkg::csr_req_s        req;
    logic [7:0]               pad_a_in, pad_a_out, pad_a_oe, rd_data_q, acc_q, flags_rd, a, b;
    logic [csr_pkg::PC_W-1:0] pc_q;
    logic [15:0]              x;
    logic [31:0]              rv;
    logic [7:0]               holes [3] = '{8'h07, 8'h20, 8'h3f};
    int                       failures, compares, cyc, seed, i;
    csr_note_s                note_q[$];
    csr_note_s                nt;

    always #12.5 core_clk = ~core_clk;

    csr_core_special_registers #(.PC_W(csr_pkg::PC_W)) dut (
        .core_clk(core_clk), .reset_n(reset_n), .req_valid(req_valid), .req(req), .req_ready(req_ready),
        .wdt_timeout(wdt_timeout), .watchdog_clear_op_op(watchdog_clear_op_op), .sleep_op(sleep_op), .pad_a_in(pad_a_in),
        .pad_a_out(pad_a_out), .pad_a_oe(pad_a_oe), .rd_data_q(rd_data_q), .acc_q(acc_q),
        .flags_rd(flags_rd), .pc_q(pc_q), .dummy_q(dummy_q));

    // One request, held until taken; a read notes its expected operand at the taking edge
    task automatic go(input csr_pkg::csr_op_e op, input logic [7:0] ad, input logic [7:0] d,
                      input logic [2:0] bs, input logic ck = 1'b0, input logic [7:0] e = 8'h00,
                      input logic [7:0] m = 8'hff, input string n = "");
        int k;
        csr_note_s w;
        k = 0;
        #1;
        req_valid = 1'b1;
        req = '{op, ad, d, bs};
        while (req_ready !== 1'b1 && k < 20)
        begin
            k++;
            @(posedge core_clk);
            #1;
        end
        if (k == 20)
        begin
            failures++;
            $display("MISMATCH req_ready expected 1 seen 0");
        end
        @(posedge core_clk);
        w.n = n;
        w.e = e;
        w.m = m;
        if (ck)
            note_q.push_back(w);
    endtask

    task automatic rd(input logic [7:0] ad, input logic [7:0] e, input logic [7:0] m, input string n);
        go(csr_pkg::OP_LDM, ad, 8'h00, 3'd0, 1'b1, e, m, n);
    endtask

    // Stores go through the accumulator, there is no direct move
    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        go(csr_pkg::OP_LDI, 8'h00, d, 3'd0);
        go(csr_pkg::OP_STM, ad, 8'h00, 3'd0);
    endtask

    // One-cycle pulse of {time-out, watchdog clear, sleep}
    task automatic ev(input logic [2:0] e);
        #1;
        req_valid = 1'b0;
        {wdt_timeout, watchdog_clear_op_op, sleep_op} = e;
        @(posedge core_clk);
        #1;
        {wdt_timeout, watchdog_clear_op_op, sleep_op} = 3'b000;
        @(posedge core_clk);
    endtask

    // Reference add or subtract: {0, ov, z, ac, c, result}
    function automatic logic [15:0] af(input logic [7:0] p, input logic [7:0] q, input logic s);
        logic [7:0] w;
        logic [8:0] t;
        logic [7:0] lo;
        logic [4:0] nb;
        w = s ? ~q : q;
        t = {1'b0, p} + {1'b0, w} + {8'h00, s};
        lo = {1'b0, p[6:0]} + {1'b0, w[6:0]} + {7'h00, s};
        nb = {1'b0, p[3:0]} + {1'b0, w[3:0]} + {4'h0, s};
        return {4'h0, lo[7] ^ t[8], t[7:0] == 8'h00, nb[4], t[8], t[7:0]};
    endfunction

    // Monitor: operand is settled by the falling edge after the taking edge
    always @(negedge core_clk)
    begin
        if (note_q.size() > 0)
        begin
            nt = note_q.pop_front();
            compares++;
            if ((rd_data_q & nt.m) !== (nt.e & nt.m))
            begin
                failures++;
                $display("MISMATCH %s expected %h seen %h", nt.n, nt.e & nt.m, rd_data_q & nt.m);
            end
        end
    end

    task automatic final_report;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Hang guard, well above the hundred and fifty or so cycles the sequence needs
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 4000)
        begin
            failures++;
            final_report();
        end
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        core_clk = 1'b0;
        reset_n = 1'b0;
        req_valid = 1'b0;
        req = '0;
        {wdt_timeout, watchdog_clear_op_op, sleep_op} = 3'b000;
        pad_a_in = 8'h3c;
        seed = 32'hb921;
        failures = 0;
        compares = 0;
        cyc = 0;
        repeat (10) @(posedge core_clk);
        #1;
        reset_n = 1'b1;
        repeat (3) @(posedge core_clk);
        rd(csr_pkg::ADR_FLAGS, 8'h00, 8'hff, "flags_reset");
        rd(csr_pkg::ADR_PT_DIR, 8'hff, 8'hff, "dir_reset");
        for (i = 0; i < 3; i++)
        begin
            wr(holes[i], 8'h5a);
            rd(holes[i], 8'h00, 8'hff, "hole");
        end
        rv = $random(seed);
        a = 8'h40 + {2'b00, rv[5:0]};
        b = rv[15:8];
        wr(csr_pkg::ADR_PTR0, a);
        wr(csr_pkg::ADR_IND0, b);
        rd(a, b, 8'hff, "ind0_target");
        rd(csr_pkg::ADR_PTR0, a, 8'hff, "ptr0_value");
        wr(csr_pkg::ADR_PTR1, a + 8'h01);
        wr(csr_pkg::ADR_IND1, ~b);
        rd(a + 8'h01, ~b, 8'hff, "ind1_target");
        rd(csr_pkg::ADR_IND0, b, 8'hff, "ind0_read");
        for (i = 0; i < 2; i++)
        begin
            wr(csr_pkg::ADR_PTR0, i[0] ? csr_pkg::ADR_IND1 : csr_pkg::ADR_IND0);
            wr(csr_pkg::ADR_IND0, 8'h77);
            rd(csr_pkg::ADR_IND0, 8'h00, 8'hff, "ind_self");
        end
        // First two cases are boundaries: equal subtract and signed overflow
        for (i = 0; i < 8; i++)
        begin
            rv = $random(seed);
            if (i == 0)
                rv[15:0] = 16'h8080;
            if (i == 1)
                rv[15:0] = 16'h017f;
            x = af(rv[7:0], rv[15:8], !i[0]);
            wr(8'h41, rv[15:8]);
            go(csr_pkg::OP_LDI, 8'h00, rv[7:0], 3'd0);
            go(i[0] ? csr_pkg::OP_ADD : csr_pkg::OP_SUB, 8'h41, 8'h00, 3'd0);
            rd(csr_pkg::ADR_ACC, x[7:0], 8'hff, "alu_result");
            rd(csr_pkg::ADR_FLAGS, x[15:8], 8'h0f, "alu_flags");
        end
        wr(csr_pkg::ADR_FLAGS, 8'hff);
        rd(csr_pkg::ADR_FLAGS, 8'h0f, 8'hff, "flags_write");
        ev(3'b001);
        rd(csr_pkg::ADR_FLAGS, 8'h1f, 8'hff, "after_sleep");
        ev(3'b100);
        rd(csr_pkg::ADR_FLAGS, 8'h3f, 8'hff, "after_timeout");
        wr(csr_pkg::ADR_FLAGS, 8'h00);
        rd(csr_pkg::ADR_FLAGS, 8'h30, 8'hff, "flags_clear");
        ev(3'b001);
        rd(csr_pkg::ADR_FLAGS, 8'h10, 8'hff, "sleep_clears_wdt");
        ev(3'b100);
        ev(3'b010);
        rd(csr_pkg::ADR_FLAGS, 8'h00, 8'hff, "wdt_clear");
        ev(3'b110);
        rd(csr_pkg::ADR_FLAGS, 8'h20, 8'hff, "set_wins");
        wr(8'h42, 8'h96);
        wr(csr_pkg::ADR_FLAGS, 8'h01);
        go(csr_pkg::OP_RLC, 8'h42, 8'h00, 3'd0);
        rd(csr_pkg::ADR_ACC, 8'h2d, 8'hff, "rlc_result");
        rd(csr_pkg::ADR_FLAGS, 8'h01, 8'h01, "rlc_carry");
        go(csr_pkg::OP_RRC, 8'h42, 8'h00, 3'd0);
        rd(csr_pkg::ADR_ACC, 8'hcb, 8'hff, "rrc_result");
        rd(csr_pkg::ADR_FLAGS, 8'h00, 8'h01, "rrc_carry");
        wr(csr_pkg::ADR_PC_LO, 8'h34);
        go(csr_pkg::OP_LDI, 8'h00, 8'h11, 3'd0);
        rd(csr_pkg::ADR_ACC, 8'h11, 8'hff, "after_jump");
        wr(csr_pkg::ADR_PT_DIR, 8'h0f);
        wr(csr_pkg::ADR_PT_DATA, 8'ha5);
        rd(csr_pkg::ADR_PT_DATA, 8'hac, 8'hff, "port_merge");
        go(csr_pkg::OP_BSET, csr_pkg::ADR_PT_DIR, 8'h00, 3'd7);
        rd(csr_pkg::ADR_PT_DIR, 8'h8f, 8'hff, "dir_bitset");
        go(csr_pkg::OP_BCLR, csr_pkg::ADR_PT_DATA, 8'h00, 3'd5);
        rd(csr_pkg::ADR_PT_DATA, 8'h0c, 8'hff, "data_bitclr");
        #1;
        req_valid = 1'b0;
        repeat (3) @(posedge core_clk);
        final_report();
    end
endmodule // tb

`default_nettype wire
